// *** tram_pkg.sv ***
/*
 Constants, register map and the line-side carrier for the receive
 alarm monitor. Assumes one receive clock, one bit per clock edge.
*/
// Contract
// - OOF when two of four framing bits wrong.
// - Count OOF events in upper error nibble.
// - 24-frame: OOF or CRC error counts low nibble.
// - 12-frame: low nibble counts Ft, plus Fs optionally.
// - Violation counter saturates at 255, then interrupts.
// - Violation counter presettable and readable any time.
// - Violations count in resync, not substitution words.
// - Error nibbles saturate at 15, share one address.
// - Error counters frozen while sync is lost.
// - Sync loss high during resync, status latched.
// - Auto mode: OOF or carrier loss starts resync.
// - Manual mode: resync only on control edge, reset.
// - Far alarm output follows detection, status latched.
// - 24-frame far alarm: sixteen 00/FF link sets.
// - 12-frame far alarm: bit-2 zeros or S-bit.
// - Violation output one bit, substitution words hidden.
// - Frame error output two bits, frame 12 optional.
// - 24-frame CRC error one-bit pulse before sync.
// - Carrier lost after 32 zeros, clears on one.
// - Reset clears registers, then forces a resync.
// - Strap low: port off, registers cleared, pins mode.
// - Five mode pins map to config, loopback latch.
// - Status read clears alarms; presets clear saturation.
// - Mask bit zero clears that pending interrupt.
`default_nettype none
package tram_pkg;
  localparam logic [2:0] ADDR_RCTL = 3'h0;
  localparam logic [2:0] ADDR_CCTL = 3'h1;
  localparam logic [2:0] ADDR_TCTL = 3'h2;
  localparam logic [2:0] ADDR_MASK = 3'h3;
  localparam logic [2:0] ADDR_STAT = 3'h4;
  localparam logic [2:0] ADDR_BVC  = 3'h5;
  localparam logic [2:0] ADDR_ECR  = 3'h6;
  localparam logic [7:0] REG_RST   = 8'h00;
  // Bit positions.
  localparam int RC_RESYNC = 0;
  localparam int RC_MANUAL = 1;
  localparam int RC_FS_CNT = 3;
  localparam int CC_LOOP   = 0;
  localparam int CC_B7     = 1;
  localparam int CC_ZSUB   = 2;
  localparam int CC_S12    = 3;
  localparam int CC_ESF    = 4;
  localparam int TC_YEL    = 0;
  localparam int TC_SEXT   = 2;
  localparam int TC_RBS    = 4;
  localparam int ST_LOS    = 0;
  localparam int ST_ZSUB   = 2;
  localparam int ST_FERR   = 3;
  localparam int ST_CL     = 4;
  localparam int ST_YEL    = 5;
  localparam int ST_ECS    = 6;
  localparam int ST_VIOLATION_COUNT_SATURATED   = 7;
  // Counts and patterns.
  localparam logic [7:0]  BV_MAX    = 8'hFF;
  localparam logic [3:0]  EC_MAX    = 4'hF;
  localparam logic [5:0]  CL_ZEROS  = 6'h20;
  localparam logic [4:0]  YEL_SETS  = 5'h10;
  localparam logic [8:0]  YEL_CHANS = 9'h100;
  localparam logic [15:0] YEL_PAT   = 16'h00FF;
  typedef enum logic [1:0] {
    TRAM_INSYNC = 2'b01,
    TRAM_RESYNC = 2'b10
  } tram_sync_e;
  // Decoded receive line events, one bit time per clock.
  typedef struct packed {
    logic bit_one;    // Received bit is a mark.
    logic fbit_time;  // Ft or FPS bit slot.
    logic fbit_err;   // That bit is wrong.
    logic fs_time;    // Fs bit slot, 12-frame mode.
    logic fs_err;     // That bit is wrong.
    logic frame12;    // The Fs slot is frame 12.
    logic crc_err;    // CRC mismatch of last multiframe.
    logic msync_pre;  // Bit before multiframe sync rises.
    logic bv;         // Violation on the bit leaving serial out.
    logic zsub_word;  // That violation is in a code word.
    logic link_valid; // Data link bit strobe.
    logic link_bit;   // Data link bit value.
    logic ch_bit2;    // Bit 2 slot of a channel.
    logic sync_found; // Synchronizer has locked.
  } tram_line_s;
endpackage
`default_nettype wire

// *** tram_top.sv ***
/*
 Receive alarm monitor: out-of-frame detection, resync control,
 saturating error counters, alarm outputs and status registers.
 Assumes a decoded line event bus and a decoded register port.
*/
`timescale 1ns/100ps
`default_nettype none
module tram_top import tram_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire tram_line_s line_in,
  input  wire logic       serial_port_select,
  input  wire logic [4:0] hw_pins,
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            int_n,
  output logic            sync_loss_out,
  output logic            far_alarm_out,
  output logic            line_violation_out,
  output logic            frame_error_out,
  output logic            carrier_lost_flag,
  output logic            loopback_out
);
  logic [7:0] rcr_q, ccr_q, tcr_q, receive_interrupt_mask_q, rsr_q, bvc_q, ecr_q;
  logic [7:0] rcr_d, ccr_d, tcr_d, receive_interrupt_mask_d, rsr_d, bvc_d, ecr_d;
  logic [7:0] rdata_d, st_set, st_clr, act;
  logic       hw_q, rc0_q, boot_q, fer_x_q, crc_q;
  logic       yel_q, s12_q, bv_q, cl_q;
  logic [2:0] hist_q, hist_d;
  logic [5:0] zc_q, zc_d;
  logic [8:0] b2_q, b2_d;
  logic [15:0] lw_q;
  logic [4:0] ys_q, ys_d, yg_q, yg_d;
  tram_sync_e sync_q, sync_d;

  // Mode strap and effective configuration.
  wire hw      = ~serial_port_select;
  wire hw_in   = hw & ~hw_q;
  wire esf     = ccr_q[CC_ESF];
  wire zsub_on = ccr_q[CC_ZSUB];
  wire s12     = ccr_q[CC_S12];
  wire both_zs = hw_pins[3] & hw_pins[4];

  // Register port decode; writes are dead in hardware mode.
  wire wr_ok = reg_wr & ~hw;
  wire w_rcr = wr_ok & (reg_addr == ADDR_RCTL);
  wire w_ccr = wr_ok & (reg_addr == ADDR_CCTL);
  wire w_tcr = wr_ok & (reg_addr == ADDR_TCTL);
  wire w_msk = wr_ok & (reg_addr == ADDR_MASK);
  wire w_bvc = wr_ok & (reg_addr == ADDR_BVC);
  wire w_ecr = wr_ok & (reg_addr == ADDR_ECR);
  wire r_st  = reg_rd & ~hw & (reg_addr == ADDR_STAT);

  // Out-of-frame: two wrong among the last four tested bits.
  wire ft_bad = line_in.fbit_time & line_in.fbit_err;
  wire [2:0] nerr = {2'b00, hist_q[0]} + {2'b00, hist_q[1]}
                  + {2'b00, hist_q[2]} + {2'b00, ft_bad};
  wire oof  = line_in.fbit_time & (nerr >= 3'd2);
  wire los  = (sync_q == TRAM_RESYNC);

  // Carrier loss after a run of zeros.
  wire cl_d    = (zc_d == CL_ZEROS);
  wire cl_rise = cl_d & ~cl_q;

  // Resync triggers.
  wire manual = rcr_q[RC_MANUAL];
  wire rc0_up = rcr_q[RC_RESYNC] & ~rc0_q;
  wire start  = boot_q
              | (~manual & (oof | cl_rise))
              | (manual & rc0_up);

  // Counter events.
  wire crc_ev = esf & line_in.msync_pre & line_in.crc_err;
  wire fs_bad = ~esf & line_in.fs_time & line_in.fs_err
              & ~(line_in.frame12 & s12);
  wire oof_inc = oof & ~los;
  wire esf_inc = ~los & (esf ? (oof | crc_ev)
               : (ft_bad | (rcr_q[RC_FS_CNT] & fs_bad)));
  wire bv_real = line_in.bv & ~(zsub_on & line_in.zsub_word);
  wire bv_inc  = bv_real;
  wire bv_sat  = bv_inc & (bvc_q == BV_MAX);
  wire ec_sat  = (oof_inc & (ecr_q[7:4] == EC_MAX))
               | (esf_inc & (ecr_q[3:0] == EC_MAX));
  wire fer_ev  = ft_bad | fs_bad;

  // Saturating increment; a full counter stays full.
  function automatic logic [7:0] bump(input logic [7:0] v,
                                      input logic [7:0] mx,
                                      input logic inc);
    bump = (inc && v != mx) ? v + 8'h01 : v;
  endfunction

  // Configuration registers and hardware mode mapping.
  always_comb begin
    rcr_d  = w_rcr ? reg_wdata : rcr_q;
    ccr_d  = w_ccr ? reg_wdata : ccr_q;
    tcr_d  = w_tcr ? reg_wdata : tcr_q;
    receive_interrupt_mask_d = w_msk ? reg_wdata : receive_interrupt_mask_q;
    if (hw) begin
      rcr_d  = REG_RST;
      receive_interrupt_mask_d = REG_RST;
      ccr_d  = REG_RST;
      tcr_d  = REG_RST;
      tcr_d[TC_SEXT] = hw_pins[0];
      ccr_d[CC_ESF]  = hw_pins[1];
      tcr_d[TC_YEL]  = hw_pins[2];
      tcr_d[TC_RBS]  = 1'b1;
      ccr_d[CC_LOOP] = both_zs;
      ccr_d[CC_B7]   = both_zs ? ccr_q[CC_B7] : hw_pins[3];
      ccr_d[CC_ZSUB] = both_zs ? ccr_q[CC_ZSUB] : hw_pins[4];
    end
  end

  // Counters, preset by the host at any time.
  always_comb begin
    bvc_d = w_bvc ? reg_wdata : bump(bvc_q, BV_MAX, bv_inc);
    ecr_d = w_ecr ? reg_wdata
          : {bump({4'h0, ecr_q[7:4]}, {4'h0, EC_MAX}, oof_inc)
              [3:0],
             bump({4'h0, ecr_q[3:0]}, {4'h0, EC_MAX}, esf_inc)
              [3:0]};
    if (hw_in) begin
      bvc_d = REG_RST;
      ecr_d = REG_RST;
    end
  end

  // Framing history and sync state machine.
  always_comb begin
    hist_d = hist_q;
    if (oof | los)
      hist_d = 3'b000;
    else if (line_in.fbit_time)
      hist_d = {hist_q[1:0], line_in.fbit_err};
    case (sync_q)
      TRAM_INSYNC: sync_d = start ? TRAM_RESYNC : TRAM_INSYNC;
      TRAM_RESYNC: sync_d = (line_in.sync_found & ~start)
                          ? TRAM_INSYNC : TRAM_RESYNC;
      default:     sync_d = TRAM_RESYNC;
    endcase
  end

  // Carrier zero run and far alarm detectors.
  always_comb begin
    zc_d = line_in.bit_one ? 6'h00
         : ((zc_q == CL_ZEROS) ? zc_q : zc_q + 6'h01);
    b2_d = b2_q;
    if (line_in.ch_bit2)
      b2_d = line_in.bit_one ? 9'h000
           : ((b2_q == YEL_CHANS) ? b2_q : b2_q + 9'h001);
    ys_d = ys_q;
    yg_d = yg_q;
    if (line_in.link_valid) begin
      if ({lw_q[14:0], line_in.link_bit} == YEL_PAT) begin
        ys_d = (ys_q == YEL_SETS) ? ys_q : ys_q + 5'h01;
        yg_d = 5'h00;
      end else begin
        yg_d = (yg_q == YEL_SETS) ? yg_q : yg_q + 5'h01;
        if (yg_d == YEL_SETS)
          ys_d = 5'h00;
      end
    end
  end

  wire yel_d = esf ? (ys_q == YEL_SETS)
             : (s12 ? s12_q : (b2_q == YEL_CHANS));

  // Status: set by events, cleared by read, mask or preset.
  always_comb begin
    st_set = 8'h00;
    st_set[ST_LOS]  = (sync_d == TRAM_RESYNC) & ~los;
    st_set[ST_ZSUB] = zsub_on & line_in.bv & line_in.zsub_word;
    st_set[ST_FERR] = fer_ev;
    st_set[ST_CL]   = cl_rise;
    st_set[ST_YEL]  = yel_d & ~yel_q;
    st_set[ST_ECS]  = ec_sat;
    st_set[ST_VIOLATION_COUNT_SATURATED] = bv_sat;
    act = {2'b00, yel_q, cl_q, fer_x_q, 2'b00, los};
    st_clr = 8'h00;
    if (r_st)
      st_clr[5:0] = ~act[5:0];
    st_clr[ST_VIOLATION_COUNT_SATURATED] = w_bvc & (reg_wdata != BV_MAX);
    st_clr[ST_ECS]  = w_ecr & (reg_wdata != 8'hFF);
    if (w_msk)
      st_clr = st_clr | ~reg_wdata;
    if (hw_in)
      st_clr = 8'hFF;
    rsr_d = (rsr_q & ~st_clr) | st_set;
  end

  // Read data mux.
  always_comb begin
    case (reg_addr)
      ADDR_RCTL: rdata_d = rcr_q;
      ADDR_CCTL: rdata_d = ccr_q;
      ADDR_TCTL: rdata_d = tcr_q;
      ADDR_MASK: rdata_d = receive_interrupt_mask_q;
      ADDR_STAT: rdata_d = rsr_q;
      ADDR_BVC:  rdata_d = bvc_q;
      ADDR_ECR:  rdata_d = ecr_q;
      default:   rdata_d = 8'h00;
    endcase
  end

  // Register file; reset clears every register.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rcr_q  <= REG_RST;
      ccr_q  <= REG_RST;
      tcr_q  <= REG_RST;
      receive_interrupt_mask_q <= REG_RST;
      rsr_q  <= REG_RST;
      bvc_q  <= REG_RST;
      ecr_q  <= REG_RST;
      hw_q   <= 1'b0;
      rc0_q  <= 1'b0;
    end else begin
      rcr_q  <= rcr_d;
      ccr_q  <= ccr_d;
      tcr_q  <= tcr_d;
      receive_interrupt_mask_q <= receive_interrupt_mask_d;
      rsr_q  <= rsr_d;
      bvc_q  <= bvc_d;
      ecr_q  <= ecr_d;
      hw_q   <= hw;
      rc0_q  <= rcr_q[RC_RESYNC];
    end
  end

  // Sync, detector state and alarm output flops.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_q  <= TRAM_INSYNC;
      boot_q  <= 1'b1;
      hist_q  <= 3'b000;
      zc_q    <= 6'h00;
      b2_q    <= 9'h000;
      lw_q    <= 16'h0000;
      ys_q    <= 5'h00;
      yg_q    <= 5'h00;
      s12_q   <= 1'b0;
      yel_q   <= 1'b0;
      cl_q    <= 1'b0;
      bv_q    <= 1'b0;
      fer_x_q <= 1'b0;
      crc_q   <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      boot_q  <= 1'b0;
      hist_q  <= hist_d;
      zc_q    <= zc_d;
      b2_q    <= b2_d;
      if (line_in.link_valid)
        lw_q  <= {lw_q[14:0], line_in.link_bit};
      ys_q    <= ys_d;
      yg_q    <= yg_d;
      if (line_in.fs_time & line_in.frame12)
        s12_q <= line_in.bit_one;
      yel_q   <= yel_d;
      cl_q    <= cl_d;
      bv_q    <= bv_real;
      fer_x_q <= fer_ev;
      crc_q   <= crc_ev;
    end
  end

  // Outputs.
  assign sync_loss_out      = los;
  assign far_alarm_out      = yel_q;
  assign line_violation_out = bv_q;
  assign carrier_lost_flag  = cl_q;
  assign loopback_out       = ccr_q[CC_LOOP];

  // Frame error holds two bits; CRC pulse is one bit wide.
  logic fer_out_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fer_out_q <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      fer_out_q <= fer_ev | fer_x_q | crc_ev;
      reg_rdata <= reg_rd ? rdata_d : reg_rdata;
    end
  end
  assign frame_error_out = fer_out_q;

  // Interrupt from any enabled pending status bit.
  assign int_n = ~|(rsr_q & receive_interrupt_mask_q);

endmodule // tram_top
`default_nettype wire

// *** tram_top_asserts.sv ***
/*
 Port checker for the receive alarm monitor.
 Assumes the bind below and the single receive clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tram_asserts import tram_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire tram_line_s line_in,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       sync_loss_out,
  input wire logic       line_violation_out,
  input wire logic       frame_error_out,
  input wire logic       carrier_lost_flag
);
  logic [5:0] zeros_q;
  logic       fe_ev;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Any line event that may raise the frame error output.
  assign fe_ev = line_in.fbit_time & line_in.fbit_err
    | line_in.fs_time & line_in.fs_err
    | line_in.msync_pre & line_in.crc_err;
  // Run of received zeros, held at the carrier loss count.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) zeros_q <= '0;
    else if (line_in.bit_one) zeros_q <= '0;
    else if (zeros_q != CL_ZEROS) zeros_q <= zeros_q + 6'h01;
  end
  // Each assertion ties an output to its cause at the inputs.
  chk_carrier_run:
    assert property (carrier_lost_flag == (zeros_q == CL_ZEROS))
    else $error("carrier flag disagrees with zero run");
  chk_bv_pulse:
    assert property (line_in.bv && !line_in.zsub_word |=> line_violation_out)
    else $error("violation not reported");
  chk_bv_quiet:
    assert property (!line_in.bv |=> !line_violation_out)
    else $error("violation output without cause");
  chk_fe_two:
    assert property (line_in.fbit_time && line_in.fbit_err && !sync_loss_out
      |=> frame_error_out [*2])
    else $error("frame error not held two bits");
  chk_fe_cause:
    assert property (frame_error_out |-> $past(fe_ev) || $past(fe_ev, 2))
    else $error("frame error output without cause");
  chk_los_end:
    assert property ($fell(sync_loss_out) |-> $past(line_in.sync_found))
    else $error("sync loss ended without lock");
  chk_rd_hold:
    assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_unmapped_zero:
    assert property (reg_rd && reg_addr == 3'h7 |=> ##1 reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // tram_asserts
bind tram_top tram_asserts u_chk (.clk_sys, .resetn, .line_in, .reg_addr,
  .reg_rd, .reg_rdata, .sync_loss_out, .line_violation_out,
  .frame_error_out, .carrier_lost_flag);
`default_nettype wire

// *** tram_line_model.sv ***
/*
 Receive line interface model feeding decoded line events.
 Assumes events are launched on the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module tram_line_model import tram_pkg::*; (
  input wire logic       clk_sys,
  output var tram_line_s line
);
  tram_line_s ev_q = '0;
  logic       zero_q = 1'b0;
  logic       lock_q = 1'b0;
  logic       wander_q = 1'b0;
  // Link data wanders between strobes so stale values never match.
  always @(negedge clk_sys) wander_q <= ~wander_q;
  // Marks by default, so carrier stays present.
  always_comb begin
    line = ev_q;
    line.bit_one = ~zero_q;
    line.sync_found = lock_q;
    if (!ev_q.link_valid) line.link_bit = wander_q;
  end
  // One bit time of events: Ft error, Fs error, violation, code word.
  task automatic pulse(input logic [3:0] k);
    @(negedge clk_sys);
    ev_q.fbit_time = k[0];
    ev_q.fbit_err = k[0];
    ev_q.fs_time = k[1];
    ev_q.fs_err = k[1];
    ev_q.bv = k[2];
    ev_q.zsub_word = k[3] & k[2];
    @(negedge clk_sys);
    ev_q = '0;
  endtask
  // One bit time of slot events: frame 12 Fs, CRC, link, bit 2, zero bit.
  task automatic slot(input logic [5:0] k);
    @(negedge clk_sys);
    ev_q.fs_time = k[0];
    ev_q.frame12 = k[0];
    ev_q.fs_err = k[0];
    ev_q.msync_pre = k[1];
    ev_q.crc_err = k[1];
    ev_q.link_valid = k[2];
    ev_q.link_bit = k[3];
    ev_q.ch_bit2 = k[4];
    zero_q = k[5];
    @(negedge clk_sys);
    ev_q = '0;
    zero_q = 1'b0;
  endtask
  // A run of received zeros.
  task automatic zeros(input int n);
    @(negedge clk_sys);
    zero_q = 1'b1;
    repeat (n) @(negedge clk_sys);
    zero_q = 1'b0;
  endtask
  // Synchronizer lock level.
  task automatic lock(input logic v);
    @(negedge clk_sys);
    lock_q = v;
  endtask
endmodule // tram_line_model
`default_nettype wire

// *** tram_top_test.sv ***
/*
 Self-checking bench for the receive alarm monitor.
 Assumes the line model as the far side and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module tram_top_test import tram_pkg::*;;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  tram_line_s line_in;
  logic       serial_port_select = 1'b1;
  logic [4:0] hw_pins = 5'h00;
  logic [2:0] reg_addr = 3'h0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic       int_n;
  logic       sync_loss_out;
  logic       far_alarm_out;
  logic       line_violation_out;
  logic       frame_error_out;
  logic       carrier_lost_flag;
  logic       loopback_out;
  int         n_errors = 0;
  int         checked = 0;
  // A 100 ns receive clock.
  always #50 clk_sys = ~clk_sys;
  tram_line_model line_m (.clk_sys, .line(line_in));
  tram_top dut (.clk_sys, .resetn, .line_in, .serial_port_select, .hw_pins,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .int_n,
    .sync_loss_out, .far_alarm_out, .line_violation_out, .frame_error_out,
    .carrier_lost_flag, .loopback_out);
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write, given a spare edge to take effect.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    check("reg_rdata", reg_rdata, exp);
  endtask
  // Bounded wait for the sync loss level; a timeout ends the run.
  task automatic wait_los(input logic v);
    for (int i = 0; i < 40 && sync_loss_out !== v; i++) @(negedge clk_sys);
    check("sync_loss_out", sync_loss_out, v);
    if (sync_loss_out !== v) stop_test();
  endtask
  task automatic resync();
    line_m.lock(1'b1);
    wait_los(1'b0);
    line_m.lock(1'b0);
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    wait_los(1'b1);
    resync();
    rd(ADDR_STAT, 8'h01);
    rd(ADDR_STAT, 8'h00);
    rd(3'h7, 8'h00);
    wr(ADDR_BVC, 8'hFD);
    repeat (3) line_m.pulse(4'h4);
    rd(ADDR_BVC, 8'hFF);
    wr(ADDR_MASK, 8'h80);
    check("int_n", int_n, 1'b0);
    wr(ADDR_MASK, 8'h00);
    check("int_n", int_n, 1'b1);
    wr(ADDR_MASK, 8'h80);
    line_m.pulse(4'h4);
    check("int_n", int_n, 1'b0);
    wr(ADDR_BVC, 8'h20);
    check("int_n", int_n, 1'b1);
    wr(ADDR_CCTL, 8'h04);
    line_m.pulse(4'hC);
    check("line_violation_out", line_violation_out, 1'b0);
    wr(ADDR_CCTL, 8'h00);
    rd(ADDR_BVC, 8'h20);
    wr(ADDR_ECR, 8'h00);
    repeat (2) line_m.pulse(4'h1);
    wait_los(1'b1);
    line_m.pulse(4'h5);
    rd(ADDR_ECR, 8'h12);
    rd(ADDR_BVC, 8'h21);
    resync();
    wr(ADDR_RCTL, 8'h08);
    wr(ADDR_ECR, 8'h0E);
    repeat (2) line_m.pulse(4'h2);
    rd(ADDR_ECR, 8'h0F);
    wr(ADDR_MASK, 8'h40);
    check("int_n", int_n, 1'b0);
    wr(ADDR_RCTL, 8'h00);
    wr(ADDR_ECR, 8'h00);
    check("int_n", int_n, 1'b1);
    line_m.pulse(4'h2);
    rd(ADDR_ECR, 8'h00);
    line_m.zeros(32);
    check("carrier_lost_flag", carrier_lost_flag, 1'b1);
    wait_los(1'b1);
    resync();
    wr(ADDR_RCTL, 8'h02);
    repeat (2) line_m.pulse(4'h1);
    check("sync_loss_out", sync_loss_out, 1'b0);
    wr(ADDR_RCTL, 8'h03);
    wait_los(1'b1);
    resync();
    repeat (256) line_m.slot(6'h30);
    @(negedge clk_sys);
    check("far_alarm_out", far_alarm_out, 1'b1);
    line_m.slot(6'h10);
    @(negedge clk_sys);
    check("far_alarm_out", far_alarm_out, 1'b0);
    wr(ADDR_CCTL, 8'h10);
    for (int i = 0; i < 256; i++) line_m.slot({2'b00, i[3], 3'b100});
    @(negedge clk_sys);
    check("far_alarm_out", far_alarm_out, 1'b1);
    wr(ADDR_ECR, 8'h00);
    line_m.slot(6'h02);
    check("frame_error_out", frame_error_out, 1'b1);
    @(negedge clk_sys);
    check("frame_error_out", frame_error_out, 1'b0);
    rd(ADDR_ECR, 8'h01);
    wr(ADDR_CCTL, 8'h08);
    line_m.slot(6'h01);
    check("frame_error_out", frame_error_out, 1'b0);
    @(negedge clk_sys);
    check("far_alarm_out", far_alarm_out, 1'b1);
    serial_port_select = 1'b0;
    hw_pins = 5'h1F;
    wr(ADDR_BVC, 8'h55);
    check("loopback_out", loopback_out, 1'b1);
    serial_port_select = 1'b1;
    hw_pins = 5'h00;
    rd(ADDR_BVC, 8'h00);
    stop_test();
  end
endmodule // tram_top_test
`default_nettype wire
